// *** hdl/crc8_tree.sv ***
// combinational 8-bit crc over one 72-bit tree input group
`timescale 1ns/1ns
module crc8_tree
   import crc_map_pkg::*;
(
   input  wire logic [TREE_W-1:0] data_in,
   output logic      [CRC_W-1:0]  crc_out
);

   // ==========================================================
   // serial form, first bit shifted in is the top input bit
   always_comb begin
      logic [CRC_W-1:0] acc;
      logic             fb;
      acc = CRC_INIT;
      fb  = 1'b0;
      for (int i = TREE_W - 1; i >= 0; i--) begin
         fb  = acc[CRC_W-1] ^ data_in[i];
         acc = {acc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
      end
      crc_out = acc;
   end

endmodule // crc8_tree

// *** hdl/write_crc_frame_mapper.sv ***
// write burst capture, crc tree input mapping and crc check with avalon registers
`timescale 1ns/1ns
// Function
// - crc eight-beat writes need column bits zero
// - four-lane: crc bits in beats eight, nine
// - eight-lane: crc bit n, mask lane bits
// - sixteen-lane uses two identical crc trees
// - lower byte bits 0-71, upper 72-143
// - sixteen-lane lanes 8-15 carry upper crc
// - column bit two picks chopped half
// - four-lane chop: 16 inputs, rest ones
// - column bit two moves beats to 4-7
// - chopped beats 4-7 high, crc unchanged
// - eight-lane chop: 36 inputs, rest ones
// - bit two clear: inputs 64-67 mask lane
// - bit two set: inputs 68-71 mask lane
// - sixteen-lane chop follows eight-lane per half
// - upper inputs 136-139 take upper mask
// - upper inputs 140-143 take upper mask
// - tree uses x^8+x^2+x+1 polynomial
// - crc starts from all zero
module write_crc_frame_mapper
   import crc_map_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        link_strobe_in,
   input  wire logic        write_frame_in,
   input  wire logic [2:0]  column_bits_in,
   input  wire logic [15:0] data_lane_in,
   input  wire logic        lower_mask_inversion_lane_in,
   input  wire logic        upper_mask_inversion_lane_in,
   output logic             crc_error_out,
   output logic             burst_done_out
);

   // ==========================================================
   // state
   typedef struct packed {
      logic                         strobe_s1;
      logic                         strobe_s2;
      logic                         strobe_prev;
      logic                         frame_s1;
      logic                         frame_s2;
      logic                         frame_prev;
      logic [LANES-1:0]             lane_s1;
      logic [LANES-1:0]             lane_s2;
      logic [2:0]                   col_s1;
      logic [2:0]                   col_s2;
      burst_state_e                 state;
      logic [3:0]                   beat;
      logic [LANES-1:0][BEATS-1:0]  cap;
      logic [2:0]                   col;
      logic [CTL_W-1:0]             ctrl;
      logic                         crc_err;
      logic                         order_err;
      logic [15:0]                  crc_calc;
      logic [15:0]                  crc_recv;
      logic [15:0]                  bursts;
      logic                         ack;
      logic [31:0]                  rdata;
      logic                         done;
   } state_s;

   state_s s;
   state_s next_s;

   // ==========================================================
   // tree input mapping for one half (eight data lanes plus mask lane)
   function automatic logic [TREE_W-1:0] tree_input(
      input logic [LANES_PER_HALF-1:0][BEATS-1:0] lanes,
      input lane_width_e                         w,
      input logic                                chop,
      input logic                                col2,
      input logic                                mask_on
   );
      logic [TREE_W-1:0] t;
      logic              used;
      t    = '1;
      used = 1'b0;
      for (int lane = 0; lane < LANES_PER_HALF; lane++) begin
         // four-lane parts feed only lanes 0-3 and have no mask lane
         used = (lane < DATA_LANES) ? (w != W_X4 || lane < X4_LANES)
                                    : (mask_on && w != W_X4);
         for (int pos = 0; pos < DATA_LANES; pos++) begin
            if (used) begin
               if (!chop) begin
                  t[lane*DATA_LANES+pos] = lanes[lane][pos];
               end else if (col2 && pos >= CHOP_BEATS) begin
                  t[lane*DATA_LANES+pos] = lanes[lane][pos-CHOP_BEATS];
               end else if (!col2 && pos < CHOP_BEATS) begin
                  t[lane*DATA_LANES+pos] = lanes[lane][pos];
               end
            end
         end
      end
      return t;
   endfunction

   // ==========================================================
   // crc trees, one per half
   lane_width_e       width;
   logic              chop;
   logic              mask_on;
   logic [TREE_W-1:0] tree_lo;
   logic [TREE_W-1:0] tree_hi;
   logic [CRC_W-1:0]  calc_lo;
   logic [CRC_W-1:0]  calc_hi;
   logic [CRC_W-1:0]  recv_lo;
   logic [CRC_W-1:0]  recv_hi;
   logic              mismatch;

   assign width   = lane_width_e'(s.ctrl[CTL_WIDTH_HI:CTL_WIDTH_LO]);
   assign chop    = s.ctrl[CTL_CHOP];
   // both enables set is a controller fault; either one admits the lane
   assign mask_on = s.ctrl[CTL_MASK_EN] | s.ctrl[CTL_INV_EN];
   assign tree_lo = tree_input(s.cap[LANES_PER_HALF-1:0], width, chop, s.col[2], mask_on);
   assign tree_hi = tree_input(s.cap[LANES-1:LANES_PER_HALF], width, chop, s.col[2],
                               mask_on);

   crc8_tree u_tree_lo (
      .data_in (tree_lo),
      .crc_out (calc_lo)
   );

   crc8_tree u_tree_hi (
      .data_in (tree_hi),
      .crc_out (calc_hi)
   );

   // received crc taken from the extra beats
   always_comb begin
      recv_lo = '0;
      recv_hi = '0;
      for (int i = 0; i < CRC_W; i++) begin
         if (width == W_X4) begin
            recv_lo[i] = (i < X4_LANES) ? s.cap[i][CRC_BEAT_A]
                                        : s.cap[i-X4_LANES][CRC_BEAT_B];
         end else begin
            recv_lo[i] = s.cap[i][CRC_BEAT_A];
         end
         recv_hi[i] = s.cap[LANES_PER_HALF+i][CRC_BEAT_A];
      end
   end

   assign mismatch = (calc_lo != recv_lo) || (width == W_X16 && calc_hi != recv_hi);

   // ==========================================================
   // register bus and burst engine
   logic       req;
   logic       strobe_edge;
   logic       frame_rise;
   logic       order_bad;
   logic       clr_crc;
   logic       clr_order;
   logic       set_crc;
   logic       set_order;

   assign req         = avs_read_in | avs_write_in;
   assign strobe_edge = s.strobe_s2 ^ s.strobe_prev;
   assign frame_rise  = s.frame_s2 & ~s.frame_prev;
   assign order_bad   = s.ctrl[CTL_CRC_EN] & ~chop & (s.col_s2 != 3'h0);

   always_comb begin
      next_s = s;
      // pin synchronisers and edge history
      next_s.strobe_s1   = link_strobe_in;
      next_s.strobe_s2   = s.strobe_s1;
      next_s.strobe_prev = s.strobe_s2;
      next_s.frame_s1    = write_frame_in;
      next_s.frame_s2    = s.frame_s1;
      next_s.frame_prev  = s.frame_s2;
      next_s.lane_s1     = {upper_mask_inversion_lane_in, data_lane_in[15:8],
                            lower_mask_inversion_lane_in, data_lane_in[7:0]};
      next_s.lane_s2     = s.lane_s1;
      next_s.col_s1      = column_bits_in;
      next_s.col_s2      = s.col_s1;
      next_s.done        = 1'b0;
      set_crc            = 1'b0;
      set_order          = 1'b0;

      case (s.state)
         ST_IDLE: begin
            if (frame_rise && s.ctrl[CTL_CRC_EN]) begin
               if (order_bad) begin
                  set_order = 1'b1;
               end else begin
                  next_s.state = ST_RECEIVE;
                  next_s.beat  = '0;
                  next_s.col   = s.col_s2;
                  next_s.cap   = '1;
               end
            end
         end
         ST_RECEIVE: begin
            if (!s.frame_s2) begin
               next_s.state = ST_IDLE;
            end else if (strobe_edge) begin
               for (int l = 0; l < LANES; l++) begin
                  next_s.cap[l][s.beat] = s.lane_s2[l];
               end
               next_s.beat = s.beat + 4'h1;
               if (s.beat == 4'(BEATS - 1)) begin
                  next_s.state = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            next_s.crc_calc = (width == W_X16) ? {calc_hi, calc_lo} : {8'h00, calc_lo};
            next_s.crc_recv = (width == W_X16) ? {recv_hi, recv_lo} : {8'h00, recv_lo};
            set_crc         = mismatch;
            next_s.bursts   = s.bursts + 16'h0001;
            next_s.done     = 1'b1;
            next_s.state    = ST_IDLE;
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase

      // avalon slave: one wait cycle, then the access completes
      next_s.ack = req & ~s.ack;
      clr_crc    = 1'b0;
      clr_order  = 1'b0;
      // writes land on the edge that sees waitrequest low; reads latch one edge earlier
      if (avs_write_in && s.ack) begin
         case (avs_address_in)
            REG_CONTROL: next_s.ctrl = avs_writedata_in[CTL_W-1:0];
            REG_STATUS: begin
               clr_crc   = avs_writedata_in[STS_CRC_ERR];
               clr_order = avs_writedata_in[STS_ORDER_ERR];
            end
            default: begin
            end
         endcase
      end else if (avs_read_in && !s.ack) begin
         case (avs_address_in)
            REG_CONTROL:  next_s.rdata = {26'h0, s.ctrl};
            REG_STATUS:   next_s.rdata = {29'h0, s.state != ST_IDLE, s.order_err, s.crc_err};
            REG_CRC_CALC: next_s.rdata = {16'h0, s.crc_calc};
            REG_CRC_RECV: next_s.rdata = {16'h0, s.crc_recv};
            REG_BURSTS:   next_s.rdata = {16'h0, s.bursts};
            default:      next_s.rdata = 32'h0;
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_s.crc_err   = (s.crc_err & ~clr_crc) | set_crc;
      next_s.order_err = (s.order_err & ~clr_order) | set_order;
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s       <= '0;
         s.cap   <= '1;
         s.ctrl  <= CTL_RESET;
         s.state <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign avs_waitrequest_out = req & ~s.ack;
   assign avs_readdata_out    = s.rdata;
   assign crc_error_out       = s.crc_err;
   assign burst_done_out      = s.done;

   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_last_beat;
      s.state == ST_RECEIVE && s.frame_s2 && strobe_edge && s.beat == 4'(BEATS - 1);
   endsequence

   sequence s_done_after;
      ##1 s.state == ST_CHECK ##1 burst_done_out;
   endsequence

   a_burst_done: assert property (s_last_beat |-> s_done_after)
      else $error("burst end did not produce a check");

   a_order_flag: assert property (
      s.state == ST_IDLE && frame_rise && s.ctrl[CTL_CRC_EN] && !chop && s.col_s2 != 3'h0
      |=> s.order_err && s.state == ST_IDLE)
      else $error("bad column order not rejected");

   a_error_on_diff: assert property (
      s.state == ST_CHECK && mismatch |=> crc_error_out [*2])
      else $error("crc difference not flagged");

   a_no_false_err: assert property (
      s.state == ST_CHECK && !mismatch && !s.crc_err |=> !crc_error_out)
      else $error("crc error raised on match");

   a_x4_chop_ones: assert property (
      chop && width == W_X4 |-> tree_lo[TREE_W-1:X4_LANES*DATA_LANES] == '1)
      else $error("four-lane chop tree not forced high");

   a_col2_shift: assert property (
      chop && s.col[2] |-> tree_lo[3:0] == 4'hf && tree_lo[7:4] == s.cap[0][3:0])
      else $error("chopped upper half not shifted");

   a_low_half_ones: assert property (
      chop && !s.col[2] |-> tree_lo[7:4] == 4'hf && tree_hi[15:12] == 4'hf)
      else $error("chopped unused positions not high");

   a_mask_low: assert property (
      chop && !s.col[2] && width != W_X4
      |-> tree_lo[67:64] == (mask_on ? s.cap[8][3:0] : 4'hf))
      else $error("lower mask inputs wrong for clear column bit");

   a_mask_high: assert property (
      chop && s.col[2] && width != W_X4
      |-> tree_lo[71:68] == (mask_on ? s.cap[8][3:0] : 4'hf))
      else $error("lower mask inputs wrong for set column bit");

   a_upper_mask: assert property (
      chop && width == W_X16
      |-> (s.col[2] ? tree_hi[71:68] : tree_hi[67:64]) ==
          (mask_on ? s.cap[17][3:0] : 4'hf))
      else $error("upper mask inputs wrong");

   a_wait_once: assert property (req && !s.ack |=> !avs_waitrequest_out || !req)
      else $error("bus access held more than one wait cycle");

   a_write_lands: assert property (
      avs_write_in && !avs_waitrequest_out && avs_address_in == REG_CONTROL
      |=> s.ctrl == $past(avs_writedata_in[CTL_W-1:0]))
      else $error("control write did not land on the completing edge");

endmodule // write_crc_frame_mapper

// *** include/crc_map_pkg.sv ***
// constants, register map and types shared by the write crc mapper
package crc_map_pkg;

   // ==========================================================
   // burst geometry
   localparam int LANES          = 18;
   localparam int LANES_PER_HALF = 9;
   localparam int DATA_LANES     = 8;
   localparam int X4_LANES       = 4;
   localparam int BEATS          = 10;
   localparam int CHOP_BEATS     = 4;
   localparam int CRC_BEAT_A     = 8;
   localparam int CRC_BEAT_B     = 9;
   localparam int TREE_W         = 72;
   localparam int CRC_W          = 8;

   // ==========================================================
   // crc generator, x^8 + x^2 + x + 1, cleared start value
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // ==========================================================
   // register byte addresses
   localparam logic [7:0] REG_CONTROL  = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_CRC_CALC = 8'h08;
   localparam logic [7:0] REG_CRC_RECV = 8'h0c;
   localparam logic [7:0] REG_BURSTS   = 8'h10;

   // control field positions
   localparam int CTL_CRC_EN   = 0;
   localparam int CTL_WIDTH_LO = 1;
   localparam int CTL_WIDTH_HI = 2;
   localparam int CTL_CHOP     = 3;
   localparam int CTL_MASK_EN  = 4;
   localparam int CTL_INV_EN   = 5;
   localparam int CTL_W        = 6;
   localparam logic [5:0] CTL_RESET = 6'h02;

   // status field positions
   localparam int STS_CRC_ERR   = 0;
   localparam int STS_ORDER_ERR = 1;
   localparam int STS_BUSY      = 2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      W_X4  = 2'b00,
      W_X8  = 2'b01,
      W_X16 = 2'b10
   } lane_width_e;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RECEIVE = 2'b01,
      ST_CHECK   = 2'b10
   } burst_state_e;

endpackage

// *** test/burst_ctrl_model.sv ***
// memory controller model that drives write bursts with the crc appended
`timescale 1ns/1ns
module burst_ctrl_model
   import crc_map_pkg::*;
(
   input  wire logic         start_in,
   input  wire lane_width_e  width_in,
   input  wire logic         chop_in,
   input  wire logic [2:0]   col_in,
   input  wire logic         mask_on_in,
   input  wire logic         corrupt_in,
   input  wire logic [143:0] payload_in,
   output logic              strobe_out,
   output logic              frame_out,
   output logic      [2:0]   col_out,
   output logic      [15:0]  lanes_out,
   output logic              lmask_out,
   output logic              umask_out,
   output logic      [15:0]  crc_out,
   output logic      [15:0]  recv_out,
   output logic              busy_out
);
   logic [143:0] t;
   logic [143:0] w;
   logic         x16;
   int           p;
   int           s;

   function automatic logic [7:0] crc8(input logic [71:0] d);
      logic [7:0] r;
      r = CRC_INIT;
      for (int i = 71; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return r;
   endfunction

   initial begin
      {strobe_out, frame_out, col_out, lanes_out, lmask_out, umask_out} = '0;
      {crc_out, recv_out, busy_out} = '0;
   end

   // ==========================================================
   // one burst per start pulse
   always @(posedge start_in) begin
      #13;
      busy_out = 1'b1;
      x16 = (width_in == W_X16);
      t = '1;
      w = '1;
      for (int h = 0; h < 2; h++) begin
         for (int l = 0; l < 9; l++) begin
            for (int b = 0; b < 8; b++) begin
               p = 72 * h + 8 * l + b;
               if ((h == 0 || x16) && (l < 4 || width_in != W_X4) &&
                   (!chop_in || b / 4 == int'(col_in[2]))) begin
                  w[p] = payload_in[p];
                  if (l < 8 || mask_on_in) t[p] = payload_in[p];
               end
            end
         end
      end
      crc_out = {crc8(t[143:72]), crc8(t[71:0])};
      if (!x16) crc_out[15:8] = 8'h00;
      recv_out = crc_out ^ {15'h0000, corrupt_in};
      col_out = col_in;
      frame_out = 1'b1;
      #200;
      for (int b = 0; b < BEATS; b++) begin
         s = chop_in ? (b < 4 ? b + 4 * col_in[2] : -1) : b;
         for (int l = 0; l < 16; l++) begin
            p = 8 * l + 8 * (l / 8) + s;
            if (b < 8) lanes_out[l] = (s < 0) ? 1'b1 : w[p];
            else if (width_in == W_X4) lanes_out[l] = (l < 4) ? recv_out[l + 4 * (b - 8)] : 1'b1;
            else lanes_out[l] = (b == 8 && (l < 8 || x16)) ? recv_out[l] : 1'b1;
         end
         lmask_out = (b < 8 && s >= 0) ? w[64 + s] : 1'b1;
         umask_out = (b < 8 && s >= 0) ? w[136 + s] : 1'b1;
         #80;
         strobe_out = ~strobe_out;
         #80;
      end
      #200;
      frame_out = 1'b0;
      // released lines show the inverse of the last beat
      lanes_out = ~lanes_out;
      lmask_out = ~lmask_out;
      umask_out = ~umask_out;
      #400;
      busy_out = 1'b0;
   end
endmodule // burst_ctrl_model

// *** test/write_crc_frame_mapper_tb_top.sv ***
// self-checking bench for the write crc frame mapper
`timescale 1ns/1ns
module write_crc_frame_mapper_tb_top
   import crc_map_pkg::*;
;
   typedef struct packed {logic [5:0] ctl; logic [2:0] col; logic bad;} row_s;
   localparam int ROWS = 13;
   localparam row_s ROW_TAB [ROWS] = '{
      '{6'h03, 3'h0, 1'b0}, '{6'h13, 3'h0, 1'b0}, '{6'h23, 3'h0, 1'b0},
      '{6'h01, 3'h0, 1'b0}, '{6'h15, 3'h0, 1'b0}, '{6'h0b, 3'h0, 1'b0},
      '{6'h1b, 3'h4, 1'b0}, '{6'h1b, 3'h0, 1'b0}, '{6'h09, 3'h4, 1'b0},
      '{6'h1d, 3'h4, 1'b0}, '{6'h2d, 3'h0, 1'b0}, '{6'h13, 3'h0, 1'b1},
      '{6'h11, 3'h0, 1'b0}
   };
   logic        mclk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [7:0]  avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, rd;
   logic        strobe, frame, lmask, umask, crc_error_out, burst_done_out;
   logic        start, chop, mask_on, bad, busy;
   logic [2:0]  col, col_pin;
   logic [15:0] lanes, crc, recv;
   logic [143:0] payload;
   lane_width_e width;
   int          mismatches, n_compared, done_cnt, got;

   write_crc_frame_mapper dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .link_strobe_in(strobe), .write_frame_in(frame), .column_bits_in(col_pin),
      .data_lane_in(lanes), .lower_mask_inversion_lane_in(lmask),
      .upper_mask_inversion_lane_in(umask), .crc_error_out(crc_error_out),
      .burst_done_out(burst_done_out));
   burst_ctrl_model ctrl_u (.start_in(start), .width_in(width), .chop_in(chop),
      .col_in(col), .mask_on_in(mask_on), .corrupt_in(bad), .payload_in(payload),
      .strobe_out(strobe), .frame_out(frame), .col_out(col_pin), .lanes_out(lanes),
      .lmask_out(lmask), .umask_out(umask), .crc_out(crc), .recv_out(recv),
      .busy_out(busy));

   always #20 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (burst_done_out === 1'b1) done_cnt <= done_cnt + 1;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      n = 0;
      // waitrequest and read data are both taken at the same rising edge
      do begin
         @(posedge mclk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      chk(32'(n < 20), 32'h1);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   // ==========================================================
   // one burst from the controller, returns the count of done pulses
   task burst(input row_s r, input int k);
      int n0;
      int n;
      @(posedge mclk_in);
      width <= lane_width_e'(r.ctl[2:1]);
      chop <= r.ctl[3];
      col <= r.col;
      mask_on <= r.ctl[4] | r.ctl[5];
      bad <= r.bad;
      payload <= {9{16'h5ac3}} ^ (144'(k + 1) * 144'h9e3779b97f4a7c15);
      n0 = done_cnt;
      @(posedge mclk_in) start <= 1'b1;
      @(posedge mclk_in) start <= 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(negedge mclk_in);
         n++;
      end
      chk(32'(n < 400), 32'h1);
      repeat (8) @(posedge mclk_in);
      got = done_cnt - n0;
   endtask

   task close_out;
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      {mclk_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
      {start, chop, mask_on, bad, col, payload} = '0;
      {mismatches, n_compared, done_cnt} = '0;
      width = W_X8;
      rst_in = 1'b1;
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      bus(1'b0, REG_CONTROL, 32'h0);
      chk(rd, 32'(CTL_RESET));
      chk(32'(crc_error_out), 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < ROWS; i++) begin
         bus(1'b1, REG_CONTROL, 32'(ROW_TAB[i].ctl));
         bus(1'b0, REG_CONTROL, 32'h0);
         chk(rd, 32'(ROW_TAB[i].ctl));
         burst(ROW_TAB[i], i);
         chk(32'(got), 32'h1);
         chk(32'(crc_error_out), 32'(ROW_TAB[i].bad));
         bus(1'b0, REG_CRC_CALC, 32'h0);
         chk(rd, 32'(crc));
         bus(1'b0, REG_CRC_RECV, 32'h0);
         chk(rd, 32'(recv));
         bus(1'b0, REG_STATUS, 32'h0);
         chk(rd & 32'h3, 32'(ROW_TAB[i].bad));
         bus(1'b1, REG_STATUS, 32'h1);
      end
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd & 32'h1, 32'h0);
      chk(32'(crc_error_out), 32'h0);
      bus(1'b1, REG_CONTROL, 32'h03);
      burst('{6'h03, 3'h5, 1'b0}, 0);
      chk(32'(got), 32'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h2);
      bus(1'b1, REG_CONTROL, 32'h02);
      burst('{6'h02, 3'h0, 1'b0}, 1);
      chk(32'(got), 32'h0);
      bus(1'b0, REG_BURSTS, 32'h0);
      chk(rd, 32'(ROWS));
      // reset in mid-run clears the count and the flags and returns the control word to CTL_RESET
      rst_in <= 1'b1;
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      bus(1'b0, REG_BURSTS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, REG_CONTROL, 32'h0);
      chk(rd, 32'(CTL_RESET));
      close_out;
   end

   initial begin
      #400000;
      mismatches++;
      close_out;
   end
endmodule // write_crc_frame_mapper_tb_top
